// ---- rtl/blr_pkg.sv ----
// shared constants, types and decode helpers for the backlight ramp control
package blr_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 40;

  // register offsets
  localparam logic [7:0] OFS_BOOST     = 8'h00;
  localparam logic [7:0] OFS_AF_THRESH = 8'h01;
  localparam logic [7:0] OFS_PWM_CFG   = 8'h02;
  localparam logic [7:0] OFS_SS_RAMP   = 8'h03;
  localparam logic [7:0] OFS_RT_RAMP   = 8'h04;
  localparam logic [7:0] OFS_RAMP_SEL  = 8'h05;
  localparam logic [7:0] OFS_FS_A      = 8'h06;
  localparam logic [7:0] OFS_BRT_A_LSB = 8'h08;
  localparam logic [7:0] OFS_BANK_EN   = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h0D;
  localparam logic [7:0] OFS_CUR_A     = 8'h0E;

  // field positions
  localparam int BOOST_FSEL_BIT = 0;
  localparam int BOOST_AUTO_BIT = 3;
  localparam int PWM_EN_A_BIT   = 0;
  localparam int PWM_POL_BIT    = 2;
  localparam int PWM_ZDIS_BIT   = 3;

  // reset values
  localparam logic [7:0] RST_BOOST     = 8'h00;
  localparam logic [7:0] RST_AF_THRESH = 8'h00;
  localparam logic [7:0] RST_PWM_CFG   = 8'h00;
  localparam logic [7:0] RST_SS_RAMP   = 8'h00;
  localparam logic [7:0] RST_RT_RAMP   = 8'h00;
  localparam logic [7:0] RST_RAMP_SEL  = 8'h00;
  localparam logic [4:0] RST_FS        = 5'h10;

  // timing
  localparam int          PWM_MIN_PULSE_NS  = 750;
  localparam logic [4:0]  PWM_MIN_CYC       =
    5'((PWM_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          RAMP_UNIT_NS      = 2000;
  localparam logic [23:0] RAMP_UNIT_CYC_DEF = 24'(RAMP_UNIT_NS / CLK_PERIOD_NS);

  // ramp phase of one bank
  typedef enum logic [1:0] {
    RP_IDLE  = 2'b00,
    RP_START = 2'b01,
    RP_STOP  = 2'b10,
    RP_RUN   = 2'b11
  } blr_phase_e;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } blr_bus_s;

  // per-bank drive to the current sink
  typedef struct packed {
    logic        gate;
    logic [10:0] code;
    logic [15:0] level;
  } blr_drive_s;

  // offset of a bank brightness register
  function automatic logic [7:0] brt_ofs(input int b, input logic msb);
    brt_ofs = 8'(OFS_BRT_A_LSB + 2 * b + int'(msb));
  endfunction : brt_ofs

endpackage : blr_pkg

// ---- rtl/blr_pwm_cond.sv ----
// pwm input conditioner: polarity and near-zero pulse rejection
`timescale 1ns/100ps
module blr_pwm_cond (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // pwm pin and settings
  input  wire logic pwm_in,
  input  wire logic active_low,
  input  wire logic zdet_dis,
  // conditioned level
  output logic      lvl_q
);
  import blr_pkg::*;

  logic       act;
  logic [4:0] cnt_q, cnt_d;
  logic       zero_q, zero_d;
  logic       lvl_d;

  // next state of pulse width counter and zero flag
  always_comb begin
    act    = pwm_in ^ active_low;
    cnt_d  = act ? ((cnt_q == 5'h1F) ? cnt_q : 5'(cnt_q + 5'h01)) : 5'h00;
    zero_d = zero_q;
    if (zdet_dis) begin
      zero_d = 1'b0;
    end else if (!act && cnt_q != 5'h00) begin
      zero_d = (cnt_q < PWM_MIN_CYC);
    end else if (act && cnt_q >= PWM_MIN_CYC) begin
      zero_d = 1'b0;
    end
    lvl_d = act && (zdet_dis || !zero_q || cnt_q >= PWM_MIN_CYC);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q  <= 5'h00;
      zero_q <= 1'b0;
      lvl_q  <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      zero_q <= zero_d;
      lvl_q  <= lvl_d;
    end
  end

  AST_ZD_BLOCK: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !zdet_dis && zero_q && cnt_q < PWM_MIN_CYC |=> !lvl_q)
    else $error("short pulse passed while near zero");

  AST_ZD_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    ce && zdet_dis |=> lvl_q == (($past(pwm_in) ^ $past(active_low))))
    else $error("pwm not followed with detection off");

endmodule : blr_pwm_cond

// ---- rtl/blr_ramp_ctrl.sv ----
// backlight brightness, ramp and boost frequency control
// Operation
// - auto frequency mode, enabled by boost control bit 3, overrides fixed select
// - compare 8-bit threshold with top 8 brightness code bits
// - code bits above threshold select 1 MHz
// - code bits at or below threshold select 500 kHz
// - bank current from full scale, 11-bit code, and duty when enabled
// - in 8-bit use the device steps the 3 low bits while ramping
// - low write held; new code applied only on high register write
// - pwm enable chosen per bank A or B
// - pwm disabled bank uses duty factor of one
// - current linear in duty, full duty gives code times full scale
// - selectable active-low pwm polarity follows low time
// - after near-zero pwm, ignore pulses until one exceeds minimum; bit 3 disables
// - 16 start-up and 16 shutdown ramp times, shared by banks
// - start-up from enable to set point, shutdown from disable to zero
// - 16 run-time ramp-up and ramp-down times, global
// - ramp select 00 own roles, 01 start/stop times everywhere, 1x instant for run-time changes, start/stop still ramp
`timescale 1ns/100ps
module blr_ramp_ctrl #(
  parameter logic [23:0] RAMP_UNIT_CYC = blr_pkg::RAMP_UNIT_CYC_DEF
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  // register port
  input  wire blr_pkg::blr_bus_s      bus,
  output logic [7:0]                  rdata_q,
  // pwm pin
  input  wire logic                   pwm_pin,
  // boost and current sinks
  output logic                        freq_1mhz_q,
  output blr_pkg::blr_drive_s [1:0]   drive_q
);
  import blr_pkg::*;

  logic [7:0]  boost_q, boost_d;
  logic [7:0]  thresh_q, thresh_d;
  logic [7:0]  pwmcfg_q, pwmcfg_d;
  logic [7:0]  ssramp_q, ssramp_d;
  logic [7:0]  rtramp_q, rtramp_d;
  logic [7:0]  rsel_q, rsel_d;
  logic [1:0]  en_q, en_d;
  logic [1:0]  en_prev_q;
  logic [4:0]  fs_q [2];
  logic [4:0]  fs_d [2];
  logic [2:0]  lsb_q [2];
  logic [2:0]  lsb_d [2];
  logic [10:0] tgt_q [2];
  logic [10:0] tgt_d [2];
  logic [10:0] cur_q [2];
  logic [10:0] cur_d [2];
  logic [10:0] goal [2];
  logic [23:0] cnt_q [2];
  logic [23:0] cnt_d [2];
  blr_phase_e  phase_q [2];
  blr_phase_e  phase_d [2];
  logic [7:0]  rdata_d;
  logic        freq_d;
  logic [7:0]  top8;
  blr_drive_s [1:0] drive_d;
  logic        pwm_lvl;

  // pwm conditioning
  blr_pwm_cond u_pwm (
    .clk        (clk),
    .reset_n    (reset_n),
    .ce         (ce),
    .pwm_in     (pwm_pin),
    .active_low (pwmcfg_q[PWM_POL_BIT]),
    .zdet_dis   (pwmcfg_q[PWM_ZDIS_BIT]),
    .lvl_q      (pwm_lvl)
  );

  // register writes and brightness latching
  always_comb begin
    boost_d  = boost_q;
    thresh_d = thresh_q;
    pwmcfg_d = pwmcfg_q;
    ssramp_d = ssramp_q;
    rtramp_d = rtramp_q;
    rsel_d   = rsel_q;
    en_d     = en_q;
    for (int b = 0; b < 2; b++) begin
      fs_d[b]  = fs_q[b];
      lsb_d[b] = lsb_q[b];
      tgt_d[b] = tgt_q[b];
    end
    if (bus.wr) begin
      case (bus.addr)
        OFS_BOOST:     boost_d  = bus.wdata;
        OFS_AF_THRESH: thresh_d = bus.wdata;
        OFS_PWM_CFG:   pwmcfg_d = bus.wdata;
        OFS_SS_RAMP:   ssramp_d = bus.wdata;
        OFS_RT_RAMP:   rtramp_d = bus.wdata;
        OFS_RAMP_SEL:  rsel_d   = bus.wdata;
        OFS_BANK_EN:   en_d     = bus.wdata[1:0];
        default:       en_d     = en_q;
      endcase
      for (int b = 0; b < 2; b++) begin
        if (bus.addr == 8'(OFS_FS_A + b)) begin
          fs_d[b] = bus.wdata[4:0];
        end
        if (bus.addr == brt_ofs(b, 1'b0)) begin
          lsb_d[b] = bus.wdata[2:0];
        end
        if (bus.addr == brt_ofs(b, 1'b1)) begin
          tgt_d[b] = {bus.wdata, lsb_q[b]};
        end
      end
    end
  end

  // ramp engine per bank
  always_comb begin
    logic       up;
    logic       inst;
    logic [3:0] idx;
    logic [23:0] period;
    up     = 1'b0;
    inst   = 1'b0;
    idx    = 4'h0;
    period = 24'h000000;
    for (int b = 0; b < 2; b++) begin
      goal[b]    = en_q[b] ? tgt_q[b] : 11'h000;
      cur_d[b]   = cur_q[b];
      cnt_d[b]   = cnt_q[b];
      phase_d[b] = phase_q[b];
      if (en_q[b] && !en_prev_q[b]) begin
        phase_d[b] = RP_START;
        cnt_d[b]   = 24'h000000;
      end else if (!en_q[b] && en_prev_q[b]) begin
        phase_d[b] = RP_STOP;
        cnt_d[b]   = 24'h000000;
      end else if (cur_q[b] == goal[b]) begin
        phase_d[b] = RP_IDLE;
      end else if (phase_q[b] == RP_IDLE) begin
        phase_d[b] = RP_RUN;
      end
      up = goal[b] > cur_q[b];
      case (phase_d[b])
        RP_START, RP_STOP: idx = up ? ssramp_q[7:4] : ssramp_q[3:0];
        RP_RUN: begin
          if (rsel_q[2*b] && !rsel_q[2*b+1]) begin
            idx = up ? ssramp_q[7:4] : ssramp_q[3:0];
          end else begin
            idx = up ? rtramp_q[7:4] : rtramp_q[3:0];
          end
        end
        default: idx = 4'h0;
      endcase
      inst   = rsel_q[2*b+1] && phase_d[b] == RP_RUN;
      period = RAMP_UNIT_CYC << idx;
      if (cur_q[b] != goal[b]) begin
        if (inst) begin
          cur_d[b] = goal[b];
          cnt_d[b] = 24'h000000;
        end else if (24'(cnt_q[b] + 24'h000001) >= period) begin
          cnt_d[b] = 24'h000000;
          cur_d[b] = up ? 11'(cur_q[b] + 11'h001) : 11'(cur_q[b] - 11'h001);
        end else begin
          cnt_d[b] = 24'(cnt_q[b] + 24'h000001);
        end
      end else begin
        cnt_d[b] = 24'h000000;
      end
    end
  end

  // boost frequency, sink drive and read data
  always_comb begin
    top8 = (cur_q[0][10:3] > cur_q[1][10:3]) ? cur_q[0][10:3] : cur_q[1][10:3];
    if (boost_q[BOOST_AUTO_BIT]) begin
      freq_d = top8 > thresh_q;
    end else begin
      freq_d = boost_q[BOOST_FSEL_BIT];
    end
    for (int b = 0; b < 2; b++) begin
      drive_d[b].gate  = pwmcfg_q[PWM_EN_A_BIT + b] ? pwm_lvl : 1'b1;
      drive_d[b].code  = cur_q[b];
      drive_d[b].level = {5'h00, cur_q[b]} * {11'h000, fs_q[b]};
    end
    rdata_d = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        OFS_BOOST:     rdata_d = boost_q;
        OFS_AF_THRESH: rdata_d = thresh_q;
        OFS_PWM_CFG:   rdata_d = pwmcfg_q;
        OFS_SS_RAMP:   rdata_d = ssramp_q;
        OFS_RT_RAMP:   rdata_d = rtramp_q;
        OFS_RAMP_SEL:  rdata_d = rsel_q;
        OFS_BANK_EN:   rdata_d = {6'h00, en_q};
        OFS_STATUS:    rdata_d = {4'h0, pwm_lvl, cur_q[1] != goal[1],
                                  cur_q[0] != goal[0], freq_1mhz_q};
        8'h06:         rdata_d = {3'h0, fs_q[0]};
        8'h07:         rdata_d = {3'h0, fs_q[1]};
        8'h08:         rdata_d = {5'h00, lsb_q[0]};
        8'h09:         rdata_d = tgt_q[0][10:3];
        8'h0A:         rdata_d = {5'h00, lsb_q[1]};
        8'h0B:         rdata_d = tgt_q[1][10:3];
        OFS_CUR_A:     rdata_d = cur_q[0][10:3];
        8'h0F:         rdata_d = cur_q[1][10:3];
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      boost_q     <= RST_BOOST;
      thresh_q    <= RST_AF_THRESH;
      pwmcfg_q    <= RST_PWM_CFG;
      ssramp_q    <= RST_SS_RAMP;
      rtramp_q    <= RST_RT_RAMP;
      rsel_q      <= RST_RAMP_SEL;
      en_q        <= 2'h0;
      en_prev_q   <= 2'h0;
      rdata_q     <= 8'h00;
      freq_1mhz_q <= 1'b0;
      drive_q     <= '0;
      for (int b = 0; b < 2; b++) begin
        fs_q[b]    <= RST_FS;
        lsb_q[b]   <= 3'h0;
        tgt_q[b]   <= 11'h000;
        cur_q[b]   <= 11'h000;
        cnt_q[b]   <= 24'h000000;
        phase_q[b] <= RP_IDLE;
      end
    end else if (ce) begin
      boost_q     <= boost_d;
      thresh_q    <= thresh_d;
      pwmcfg_q    <= pwmcfg_d;
      ssramp_q    <= ssramp_d;
      rtramp_q    <= rtramp_d;
      rsel_q      <= rsel_d;
      en_q        <= en_d;
      en_prev_q   <= en_q;
      rdata_q     <= rdata_d;
      freq_1mhz_q <= freq_d;
      drive_q     <= drive_d;
      for (int b = 0; b < 2; b++) begin
        fs_q[b]    <= fs_d[b];
        lsb_q[b]   <= lsb_d[b];
        tgt_q[b]   <= tgt_d[b];
        cur_q[b]   <= cur_d[b];
        cnt_q[b]   <= cnt_d[b];
        phase_q[b] <= phase_d[b];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence msb_wr_a;
    ce && bus.wr && bus.addr == brt_ofs(0, 1'b1);
  endsequence

  sequence lsb_wr_a;
    ce && bus.wr && bus.addr == brt_ofs(0, 1'b0);
  endsequence

  AST_AUTO_HI: assert property (ce && boost_q[BOOST_AUTO_BIT] && top8 > thresh_q
    |=> freq_1mhz_q)
    else $error("auto mode above threshold not at 1 MHz");

  AST_AUTO_LO: assert property (ce && boost_q[BOOST_AUTO_BIT] && top8 <= thresh_q
    |=> !freq_1mhz_q)
    else $error("auto mode at or below threshold not at 500 kHz");

  AST_FIXED: assert property (ce && !boost_q[BOOST_AUTO_BIT]
    |=> freq_1mhz_q == $past(boost_q[BOOST_FSEL_BIT]))
    else $error("fixed frequency select not followed");

  AST_LSB_HOLD: assert property (lsb_wr_a |=> $stable(tgt_q[0]))
    else $error("low brightness write changed target");

  AST_MSB_COMMIT: assert property (msb_wr_a
    |=> tgt_q[0] == {$past(bus.wdata), $past(lsb_q[0])})
    else $error("high brightness write did not commit code");

  AST_INSTANT: assert property (ce && rsel_q[1]
    && (phase_q[0] == RP_IDLE || phase_q[0] == RP_RUN)
    && en_q[0] == en_prev_q[0] && cur_q[0] != goal[0] |=> cur_q[0] == $past(goal[0]))
    else $error("instant ramp select did not jump");

  AST_STEP_ONE: assert property (ce && !rsel_q[1]
    |=> cur_q[0] == $past(cur_q[0]) || cur_q[0] == 11'($past(cur_q[0]) + 11'h001)
        || cur_q[0] == 11'($past(cur_q[0]) - 11'h001))
    else $error("ramp moved more than one count");

  AST_GATE_OFF: assert property (ce && reset_n && !pwmcfg_q[PWM_EN_A_BIT]
    |=> drive_q[0].gate)
    else $error("pwm disabled bank not at full duty");

  AST_GATE_ON: assert property (ce && pwmcfg_q[PWM_EN_A_BIT]
    |=> drive_q[0].gate == $past(pwm_lvl))
    else $error("pwm enabled bank not following pwm");

endmodule : blr_ramp_ctrl

// ---- testbench/blr_pwm_host.sv ----
// host-side model driving the pwm pin
`timescale 1ns/100ps
module blr_pwm_host (
  // clock
  input  wire logic clk,
  // pwm pin
  output logic      pwm_pin
);
  localparam int MIN_PD = 250; // 100 kHz at 25 MHz

  // pin idles low until the bench asks for activity
  initial pwm_pin = 1'b0;

  // hold a steady level on the pin
  task automatic level(input logic v);
    @(posedge clk);
    pwm_pin <= v;
  endtask : level

  // one high pulse, then low for the rest of a legal period
  task automatic pulse(input int w);
    @(posedge clk);
    pwm_pin <= 1'b1;
    repeat (w) @(posedge clk);
    pwm_pin <= 1'b0;
    repeat ((w < MIN_PD) ? MIN_PD - w : 1) @(posedge clk);
  endtask : pulse
endmodule : blr_pwm_host

// ---- testbench/test_backlight_brightness_ramp_control.sv ----
// self-checking bench for the backlight ramp control
`timescale 1ns/100ps
module test_backlight_brightness_ramp_control;
  import blr_pkg::*;
  logic             clk;
  logic             reset_n;
  logic             ce;
  blr_bus_s         bus;
  logic [7:0]       rdata_q;
  logic             pwm_pin;
  logic             freq_1mhz_q;
  blr_drive_s [1:0] drive_q;
  logic [7:0]       exp_q[$];
  logic             rd_pend;
  logic [10:0]      prev_code;
  logic             step_on;
  int               gate_hits;
  int               bad_count;
  int               check_count;
  logic [7:0]       msb;
  int               n;
  logic [7:0]       rst_tab [8] = '{RST_BOOST, RST_AF_THRESH, RST_PWM_CFG, RST_SS_RAMP,
                                    RST_RT_RAMP, RST_RAMP_SEL, 8'(RST_FS), 8'(RST_FS)};
  // select, start/stop, run, msb, cycles
  int               rt_tab [4][5] = '{'{8'h01, 8'h10, 8'h00, 8'h21, 8'h10},
                                      '{8'h00, 8'h10, 8'h20, 8'h22, 8'h20},
                                      '{8'h00, 8'h10, 8'h02, 8'h21, 8'h20},
                                      '{8'h01, 8'h01, 8'h02, 8'h20, 8'h10}};

  // device and host model
  blr_ramp_ctrl #(.RAMP_UNIT_CYC(24'h000001)) u_dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .bus(bus), .rdata_q(rdata_q),
    .pwm_pin(pwm_pin), .freq_1mhz_q(freq_1mhz_q), .drive_q(drive_q));
  blr_pwm_host u_host (.clk(clk), .pwm_pin(pwm_pin));

  // clock
  initial clk = 1'b0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  // one strobe cycle on the register port, write when w is high
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
  endtask : put

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    put(a, 8'h00, 1'b0);
  endtask : rd

  task automatic wait_code(input logic [10:0] t, output int c);
    c = 0;
    while (drive_q[0].code !== t && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_code

  task automatic near(input int got, input int exp);
    chk_port({15'h0, got >= exp - 4 && got <= exp + 4}, 16'h0001);
  endtask : near

  task automatic af(input logic [7:0] b, input logic [7:0] t, input logic e);
    wr(OFS_AF_THRESH, t);
    wr(OFS_BOOST, b);
    repeat (3) @(negedge clk);
    chk_port({15'h0, freq_1mhz_q}, {15'h0, e});
  endtask : af

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // read data checked one cycle after each read strobe
  always @(posedge clk) begin
    if (rd_pend) chk_rd(rdata_q, exp_q.pop_front());
    rd_pend <= bus.rd & ce;
    prev_code <= drive_q[0].code;
  end

  // code moves one count at a time; count gate high cycles
  always @(negedge clk) begin
    if (step_on)
      chk_port({15'h0, 11'(drive_q[0].code - prev_code + 11'h001) <= 11'h002}, 16'h0001);
    if (drive_q[0].gate === 1'b1) gate_hits++;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    ce = 1'b1;
    reset_n = 1'b0;
    bus = '0;
    rd_pend = 1'b0;
    step_on = 1'b0;
    bad_count = 0;
    check_count = 0;
    gate_hits = 0;
    void'($urandom(57));
    msb = 8'h40 + 8'($urandom % 128);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, unmapped place, write with clock enable low
    foreach (rst_tab[a]) rd(8'(a), rst_tab[a]);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    ce <= 1'b0;
    wr(OFS_AF_THRESH, 8'h55);
    ce <= 1'b1;
    rd(OFS_AF_THRESH, 8'h00);
    // low byte alone holds, high byte commits, start ramp
    wr(OFS_BANK_EN, 8'h01);
    wr(OFS_BRT_A_LSB, 8'h05);
    repeat (4) @(negedge clk);
    chk_port({5'h0, drive_q[0].code}, 16'h0000);
    rd(OFS_BRT_A_LSB, 8'h05);
    step_on = 1'b1;
    wr(OFS_BRT_A_LSB + 8'h01, msb);
    wait_code({msb, 3'h5}, n);
    near(n, int'({msb, 3'h5}));
    chk_port({5'h0, drive_q[0].code}, {5'h0, msb, 3'h5});
    chk_port(drive_q[0].level, 16'({msb, 3'h5}) * 16'(RST_FS));
    rd(OFS_CUR_A, msb);
    // automatic boost frequency around the threshold, and fixed select
    af(8'h08, msb, 1'b0);
    af(8'h08, msb - 8'h01, 1'b1);
    af(8'h01, 8'hFF, 1'b1);
    af(8'h09, 8'hFF, 1'b0);
    // instant select, low bits only via a high byte rewrite
    wr(OFS_RAMP_SEL, 8'h02);
    wr(OFS_BRT_A_LSB, 8'h00);
    step_on = 1'b0;
    wr(OFS_BRT_A_LSB + 8'h01, 8'h20);
    repeat (3) @(negedge clk);
    chk_port({5'h0, drive_q[0].code}, 16'h0100);
    @(posedge clk);
    step_on = 1'b1;
    // run-time ramps under selects 00 and 01, both directions
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SS_RAMP, 8'(rt_tab[i][1]));
      wr(OFS_RT_RAMP, 8'(rt_tab[i][2]));
      wr(OFS_RAMP_SEL, 8'(rt_tab[i][0]));
      wr(OFS_BRT_A_LSB + 8'h01, 8'(rt_tab[i][3]));
      wait_code({8'(rt_tab[i][3]), 3'h0}, n);
      near(n, rt_tab[i][4]);
    end
    // shutdown ramp to zero
    wr(OFS_SS_RAMP, 8'h01);
    wr(OFS_BANK_EN, 8'h00);
    wait_code(11'h000, n);
    near(n, 512);
    // pwm gating per bank and polarity
    wr(OFS_PWM_CFG, 8'h09);
    u_host.level(1'b1);
    repeat (3) @(negedge clk);
    chk_port({14'h0, drive_q[1].gate, drive_q[0].gate}, 16'h0003);
    u_host.level(1'b0);
    repeat (3) @(negedge clk);
    chk_port({14'h0, drive_q[1].gate, drive_q[0].gate}, 16'h0002);
    wr(OFS_PWM_CFG, 8'h0D);
    repeat (3) @(negedge clk);
    chk_port({14'h0, drive_q[1].gate, drive_q[0].gate}, 16'h0003);
    // near-zero rejection, then detection disabled
    wr(OFS_PWM_CFG, 8'h01);
    u_host.pulse(5);
    gate_hits = 0;
    u_host.pulse(5);
    chk_port(16'(gate_hits), 16'h0000);
    gate_hits = 0;
    u_host.pulse(30);
    chk_port({15'h0, gate_hits > 0}, 16'h0001);
    n = 2 + int'($urandom % 12);
    wr(OFS_PWM_CFG, 8'h09);
    gate_hits = 0;
    u_host.pulse(n);
    chk_port(16'(gate_hits), 16'(n));
    test_done();
  end
endmodule : test_backlight_brightness_ramp_control
